/* File: include/twm_pkg.sv */
// Purpose: constants for the two-wire master transmitter
// Assumes: 25 MHz ref_clk, 100 kHz bus bit rate
// Notes:   register offsets are word indices on the plain port
package twm_pkg;
    // register map
    localparam int          ADDR_W        = 2;
    localparam logic [1:0]  OFF_CONTROL   = 2'h0;
    localparam logic [1:0]  OFF_STATUS    = 2'h1;
    localparam logic [1:0]  OFF_DATA      = 2'h2;
    // control_register bit positions
    localparam int          CTL_STEP      = 7;
    localparam int          CTL_ACK_EN    = 6;
    localparam int          CTL_START     = 5;
    localparam int          CTL_STOP      = 4;
    localparam int          CTL_WCOL      = 3;
    localparam int          CTL_ENABLE    = 2;
    localparam int          CTL_IE        = 0;
    // status_register layout
    localparam int          STA_CODE_LSB  = 3;
    localparam int          STA_PRESC_W   = 2;
    localparam logic [7:0]  DATA_RESET    = 8'hFF;
    // status codes, prescaler bits zero
    localparam logic [7:0]  SC_START      = 8'h08;
    localparam logic [7:0]  SC_RSTART     = 8'h10;
    localparam logic [7:0]  SC_AW_ACK     = 8'h18;
    localparam logic [7:0]  SC_AW_NACK    = 8'h20;
    localparam logic [7:0]  SC_D_ACK      = 8'h28;
    localparam logic [7:0]  SC_D_NACK     = 8'h30;
    localparam logic [7:0]  SC_LOST       = 8'h38;
    localparam logic [7:0]  SC_AR_ACK     = 8'h40;
    localparam logic [7:0]  SC_AR_NACK    = 8'h48;
    localparam logic [7:0]  SC_IDLE       = 8'hF8;
    // bus timing
    localparam int          CLK_HZ        = 25000000;
    localparam int          BIT_HZ        = 100000;
    localparam int          CNT_W         = 16;
    // quarter bit period, rounded down
    localparam int          QTR_CYC       = CLK_HZ / (4 * BIT_HZ);
    localparam logic [3:0]  LAST_BIT      = 4'h8;
    localparam logic [1:0]  PH_LAST       = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WFREE,
        ST_START,
        ST_HOLD,
        ST_BYTE,
        ST_STOP
    } twm_state_e;
endpackage

/* File: hw/twm_master_tx.sv */
// Purpose: two-wire bus master transmitter with step-wise software control
// Assumes: open-drain scl/sda, pins asynchronous to ref_clk
// Notes:   master receive data phase not built; mode is only entered
`timescale 1ns/10ps
module twm_master_tx
    import twm_pkg::*;
#(
    parameter int QTR = QTR_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic              scl_in,
    output logic                   scl_out,
    output logic                   scl_oe,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    output logic                   irq
);

    typedef struct packed {
        twm_state_e             state;
        logic [1:0]             ph;
        logic [CNT_W-1:0]       cnt;
        logic [3:0]             bitn;
        logic                   step;
        logic                   ack_en;
        logic                   sta;
        logic                   sto;
        logic                   wcol;
        logic                   en;
        logic                   ie;
        logic [7:0]             code;
        logic [STA_PRESC_W-1:0] presc;
        logic [7:0]             data;
        logic [7:0]             sh;
        logic                   addr_ph;
        logic                   rep;
        logic                   master;
        logic                   mr_mode;
        logic                   lost;
        logic                   ackd;
        logic                   scl_low;
        logic                   sda_low;
        logic [1:0]             s1;
        logic [1:0]             s2;
        logic [1:0]             s3;
        logic                   busy;
        logic [7:0]             rdata;
        logic                   irq;
    } twm_regs_s;

    twm_regs_s q;
    twm_regs_s n;

    function automatic logic [7:0] ctl_word(input twm_regs_s r);
        logic [7:0] w;
        w             = 8'h00;
        w[CTL_STEP]   = r.step;
        w[CTL_ACK_EN] = r.ack_en;
        w[CTL_START]  = r.sta;
        w[CTL_STOP]   = r.sto;
        w[CTL_WCOL]   = r.wcol;
        w[CTL_ENABLE] = r.en;
        w[CTL_IE]     = r.ie;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic tick;
    logic scl_hi;
    logic sda_hi;
    logic out_bit;

    always_comb begin
        n       = q;
        // s1 feeds only s2; bit 1 is scl, bit 0 is sda
        n.s1    = {scl_in, sda_in};
        n.s2    = q.s1;
        n.s3    = q.s2;
        scl_hi  = q.s2[1];
        sda_hi  = q.s2[0];
        tick    = (q.cnt == CNT_W'(QTR - 1));
        n.cnt   = tick ? '0 : q.cnt + 1'b1;
        out_bit = (q.bitn == LAST_BIT) ? 1'b1 : q.sh[7];
        // start seen on the bus marks it busy, stop frees it
        if (q.s3[1] && scl_hi && q.s3[0] && !sda_hi) begin
            n.busy = 1'b1;
        end else if (q.s3[1] && scl_hi && !q.s3[0] && sda_hi) begin
            n.busy = 1'b0;
        end

        // software side first so hardware sets below win
        if (reg_wr && reg_addr == OFF_CONTROL) begin
            if (reg_wdata[CTL_STEP]) begin
                n.step = 1'b0;
            end
            n.ack_en = reg_wdata[CTL_ACK_EN];
            n.sta    = reg_wdata[CTL_START];
            n.sto    = reg_wdata[CTL_STOP];
            n.en     = reg_wdata[CTL_ENABLE];
            n.ie     = reg_wdata[CTL_IE];
        end
        if (reg_wr && reg_addr == OFF_STATUS) begin
            n.presc = reg_wdata[STA_PRESC_W-1:0];
        end
        // data write only under step flag
        if (reg_wr && reg_addr == OFF_DATA) begin
            if (q.step) begin
                n.data = reg_wdata;
                n.wcol = 1'b0;
            end else begin
                n.wcol = 1'b1;
            end
        end
        n.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                OFF_CONTROL: n.rdata = ctl_word(q);
                OFF_STATUS:  n.rdata = {q.code[7:STA_CODE_LSB], 1'b0, q.presc};
                OFF_DATA:    n.rdata = q.data;
                default:     n.rdata = 8'h00;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        unique case (q.state)
            ST_IDLE: begin
                n.cnt = '0;
                if (q.en && q.sta && !q.step) begin
                    n.state = ST_WFREE;
                end
            end
            ST_WFREE: begin
                n.cnt = '0;
                if (!q.busy && scl_hi && sda_hi) begin
                    n.state = ST_START;
                    n.ph    = 2'h0;
                    n.rep   = 1'b0;
                end
            end
            ST_START: begin
                if (tick) begin
                    unique case (q.ph)
                        2'h0: begin
                            n.sda_low = 1'b0;
                            n.ph      = 2'h1;
                        end
                        2'h1: begin
                            n.scl_low = 1'b0;
                            if (scl_hi) begin
                                n.ph = 2'h2;
                            end
                        end
                        2'h2: begin
                            n.sda_low = 1'b1;
                            n.ph      = PH_LAST;
                        end
                        2'h3: begin
                            // master after start, code 08 or 10
                            n.scl_low = 1'b1;
                            n.step    = 1'b1;
                            n.code    = q.rep ? SC_RSTART : SC_START;
                            n.master  = 1'b1;
                            n.addr_ph = 1'b1;
                            n.mr_mode = 1'b0;
                            n.state   = ST_HOLD;
                        end
                    endcase
                end
            end
            // suspended while step flag is set
            ST_HOLD: begin
                n.cnt = '0;
                n.ph  = 2'h0;
                if (!q.step) begin
                    if (q.lost) begin
                        n.lost  = 1'b0;
                        n.state = q.sta ? ST_WFREE : ST_IDLE;
                    end else if (q.sto) begin
                        n.state = ST_STOP;
                    end else if (q.sta) begin
                        n.state = ST_START;
                        n.rep   = 1'b1;
                    end else if (!q.mr_mode) begin
                        n.state = ST_BYTE;
                        n.sh    = q.data;
                        n.bitn  = 4'h0;
                    end
                end
            end
            ST_BYTE: begin
                if (tick) begin
                    unique case (q.ph)
                        2'h0: begin
                            n.sda_low = !out_bit;
                            n.ph      = 2'h1;
                        end
                        2'h1: begin
                            n.scl_low = 1'b0;
                            if (scl_hi) begin
                                n.ph = 2'h2;
                            end
                        end
                        2'h2: begin
                            n.ph   = PH_LAST;
                            n.ackd = !sda_hi;
                            if (q.bitn != LAST_BIT && out_bit && !sda_hi) begin
                                n.sda_low = 1'b0;
                                n.scl_low = 1'b0;
                                n.master  = 1'b0;
                                n.mr_mode = 1'b0;
                                n.lost    = 1'b1;
                                n.step    = 1'b1;
                                n.code    = SC_LOST;
                                n.state   = ST_HOLD;
                            end
                        end
                        2'h3: begin
                            n.scl_low = 1'b1;
                            n.ph      = 2'h0;
                            if (q.bitn == LAST_BIT) begin
                                n.step    = 1'b1;
                                n.state   = ST_HOLD;
                                n.addr_ph = 1'b0;
                                if (q.addr_ph && q.data[0]) begin
                                    n.mr_mode = 1'b1;
                                    n.code    = q.ackd ? SC_AR_ACK : SC_AR_NACK;
                                end else if (q.addr_ph) begin
                                    n.code = q.ackd ? SC_AW_ACK : SC_AW_NACK;
                                end else begin
                                    n.code = q.ackd ? SC_D_ACK : SC_D_NACK;
                                end
                            end else begin
                                n.sh   = {q.sh[6:0], 1'b0};
                                n.bitn = q.bitn + 1'b1;
                            end
                        end
                    endcase
                end
            end
            ST_STOP: begin
                if (tick) begin
                    unique case (q.ph)
                        2'h0: begin
                            n.sda_low = 1'b1;
                            n.ph      = 2'h1;
                        end
                        2'h1: begin
                            n.scl_low = 1'b0;
                            if (scl_hi) begin
                                n.ph = 2'h2;
                            end
                        end
                        2'h2: begin
                            n.sda_low = 1'b0;
                            n.ph      = PH_LAST;
                        end
                        2'h3: begin
                            n.sto     = 1'b0;
                            n.master  = 1'b0;
                            n.mr_mode = 1'b0;
                            n.ph      = 2'h0;
                            n.state   = q.sta ? ST_WFREE : ST_IDLE;
                        end
                    endcase
                end
            end
        endcase

        // disabled interface lets go of the bus at once
        if (!q.en) begin
            n.state   = ST_IDLE;
            n.scl_low = 1'b0;
            n.sda_low = 1'b0;
            n.master  = 1'b0;
            n.mr_mode = 1'b0;
            n.lost    = 1'b0;
        end
        n.irq = n.step && n.ie;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q       <= '0;
            q.state <= ST_IDLE;
            q.code  <= SC_IDLE;
            q.data  <= DATA_RESET;
            q.s1    <= 2'h3;
            q.s2    <= 2'h3;
            q.s3    <= 2'h3;
        end else if (clk_en) begin
            q <= n;
        end
    end

    assign reg_rdata = q.rdata;
    assign scl_oe    = q.scl_low;
    assign sda_oe    = q.sda_low;
    // open drain: only ever drives low
    assign scl_out   = 1'b0;
    assign sda_out   = 1'b0;
    assign irq       = q.irq;

    ////////////////////////////////////////////////////////////////////////
    property p_free_start;
        @(posedge ref_clk) disable iff (reset)
        q.state == ST_WFREE ##1 q.state == ST_START |-> $past(!q.busy && q.s2 == 2'h3);
    endproperty
    a_free_start: assert property (p_free_start) else $error("start issued on busy bus");

    property p_start_code;
        @(posedge ref_clk) disable iff (reset)
        $rose(q.step) && $past(q.state) == ST_START |-> q.code == ($past(q.rep) ? SC_RSTART : SC_START);
    endproperty
    a_start_code: assert property (p_start_code) else $error("wrong code after start");

    property p_clear_step;
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_wr && reg_addr == OFF_CONTROL && reg_wdata[CTL_STEP] && q.state == ST_HOLD
        |=> !q.step;
    endproperty
    a_clear_step: assert property (p_clear_step) else $error("step flag not cleared");

    property p_wcol;
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_wr && reg_addr == OFF_DATA && !q.step |=> q.wcol && q.data == $past(q.data);
    endproperty
    a_wcol: assert property (p_wcol) else $error("collision write not refused");

    property p_stop_clear;
        @(posedge ref_clk) disable iff (reset)
        $past(q.state) == ST_STOP && q.state != ST_STOP && q.en |-> !q.sto && !q.master;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop bit left set");

    property p_byte_code;
        @(posedge ref_clk) disable iff (reset)
        $rose(q.step) && $past(q.state) == ST_BYTE && !q.lost && !$past(q.addr_ph)
        |-> q.code == ($past(q.ackd) ? SC_D_ACK : SC_D_NACK);
    endproperty
    a_byte_code: assert property (p_byte_code) else $error("wrong code after data");

    property p_addr_code;
        @(posedge ref_clk) disable iff (reset)
        $rose(q.step) && $past(q.state) == ST_BYTE && !q.lost && $past(q.addr_ph) && !$past(q.data[0])
        |-> q.code == ($past(q.ackd) ? SC_AW_ACK : SC_AW_NACK) && q.master;
    endproperty
    a_addr_code: assert property (p_addr_code) else $error("wrong code after address");

    property p_read_mode;
        @(posedge ref_clk) disable iff (reset)
        $rose(q.step) && $past(q.state) == ST_BYTE && !q.lost && $past(q.addr_ph) && $past(q.data[0])
        |-> q.mr_mode;
    endproperty
    a_read_mode: assert property (p_read_mode) else $error("receive mode not entered");

    property p_lost;
        @(posedge ref_clk) disable iff (reset)
        $rose(q.lost) |-> q.step && q.code == SC_LOST && !q.master && !q.sda_low && !q.scl_low;
    endproperty
    a_lost: assert property (p_lost) else $error("arbitration loss mishandled");

    property p_suspend;
        @(posedge ref_clk) disable iff (reset)
        q.state == ST_HOLD && q.step && q.en |=> q.state == ST_HOLD && $stable(q.scl_low);
    endproperty
    a_suspend: assert property (p_suspend) else $error("bus moved while suspended");

    property p_irq;
        @(posedge ref_clk) disable iff (reset)
        $rose(q.step) && q.ie |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule

/* File: test/twm_slave_model.sv */
// Purpose: behavioural slave receiver on the two-wire bus
// Assumes: open-drain wires resolved by the bench, pull-ups on both
// Notes:   acks each ninth bit while ack_on is high; never stretches scl
`timescale 1ns/10ps
module twm_slave_model (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_on,
    output logic            sda_pull,
    output logic [7:0]      last_byte,
    output logic [7:0]      stop_cnt
);
    int          bit_n;
    logic        active;
    logic [7:0]  shift_q;
    initial begin
        sda_pull  = 1'b0;
        last_byte = 8'h00;
        stop_cnt  = 8'h00;
        bit_n     = 0;
        active    = 1'b0;
        shift_q   = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    // frame opens on start
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            bit_n  = 0;
            active = 1'b1;
        end
    end
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            active   = 1'b0;
            sda_pull = 1'b0;
            stop_cnt = stop_cnt + 8'h01;
        end
    end
    always @(posedge scl) begin
        if (active && bit_n < 8) begin
            shift_q = {shift_q[6:0], sda};
            bit_n   = bit_n + 1;
        end
    end
    // ack driven from the eighth falling scl edge, released after the ninth clock
    always @(negedge scl) begin
        if (active && bit_n == 8) begin
            sda_pull  = ack_on;
            last_byte = shift_q;
            bit_n     = 9;
        end else if (active && bit_n == 9) begin
            sda_pull = 1'b0;
            bit_n    = 0;
        end
    end
endmodule

/* File: test/tb_top.sv */
// Purpose: register-level test of the two-wire master transmitter
// Assumes: QTR of 2 to keep bus frames short
// Notes:   rival master modelled by one extra sda pull-down
`timescale 1ns/10ps
module tb_top
    import twm_pkg::*;
;
    logic              ref_clk;
    logic              reset;
    logic              clk_en;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0]        reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [7:0]        reg_rdata;
    logic              scl_oe;
    logic              sda_oe;
    logic              irq;
    logic              slave_pull;
    logic              rival_pull;
    logic              ack_on;
    logic [7:0]        last_byte;
    logic [7:0]        stop_cnt;
    logic [7:0]        s0;
    wire               scl_w = ~scl_oe;
    wire               sda_w = ~(sda_oe | slave_pull | rival_pull);
    int                n_mismatch = 0;
    int                n_compared = 0;
    int                cycles = 0;

    twm_master_tx #(.QTR(2)) dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_w),
        .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .irq(irq));
    twm_slave_model slave (.scl(scl_w), .sda(sda_w), .ack_on(ack_on), .sda_pull(slave_pull),
        .last_byte(last_byte), .stop_cnt(stop_cnt));

    initial begin
        ref_clk = 1'b0;
    end
    always #20 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ceiling well above the thousand or so cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            $display("ERROR timeout expected end seen hang");
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask
    task automatic rchk(input string what, input logic [1:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(what, reg_rdata & m, exp);
    endtask
    // bounded poll; the step flag shows on irq since ie is always set
    task automatic wait_step(input logic [7:0] code);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        #1;
        chk("step flag", {7'h00, irq}, 8'h01);
        // prescaler bits masked before comparing
        rchk("status", OFF_STATUS, 8'hF8, code);
    endtask
    task automatic wait_stop();
        int n;
        n = 0;
        while (stop_cnt === s0 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        repeat (4) @(posedge ref_clk);
        #1;
        chk("stops", stop_cnt, s0 + 8'h01);
        rchk("stop bit", OFF_CONTROL, 8'h10, 8'h00);
    endtask
    // every command keeps enable and ie
    task automatic send(input logic [7:0] d, input logic [7:0] code);
        wr(OFF_DATA, d);
        rchk("collision", OFF_CONTROL, 8'h08, 8'h00);
        wr(OFF_CONTROL, 8'h85);
        chk("irq cleared", {7'h00, irq}, 8'h00);
        wait_step(code);
        chk("slave byte", last_byte, d);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ack_on = 1'b1;
        rival_pull = 1'b0;
        s0 = 8'h00;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        rchk("control", OFF_CONTROL, 8'hFF, 8'h00);
        rchk("status", OFF_STATUS, 8'hFF, SC_IDLE);
        rchk("data", OFF_DATA, 8'hFF, DATA_RESET);
        rchk("unmapped", 2'h3, 8'hFF, 8'h00);
        // prescaler bits read back; later status checks must mask them
        wr(OFF_STATUS, 8'h03);
        rchk("prescaler", OFF_STATUS, 8'hFF, 8'hFB);
        wr(OFF_DATA, 8'h11);
        rchk("data", OFF_DATA, 8'hFF, DATA_RESET);
        rchk("collision", OFF_CONTROL, 8'h08, 8'h08);
        $display("test registers done");
        wr(OFF_CONTROL, 8'hE5);
        wait_step(SC_START);
        // start request and collision stay set until software acts
        rchk("control", OFF_CONTROL, 8'hFF, 8'hED);
        repeat (20) @(posedge ref_clk);
        chk("suspended", {6'h00, scl_oe, irq}, 8'h03);
        // frozen clock enable must swallow the clearing write
        clk_en <= 1'b0;
        wr(OFF_CONTROL, 8'h85);
        clk_en <= 1'b1;
        rchk("frozen", OFF_CONTROL, 8'h80, 8'h80);
        send(8'h54, SC_AW_ACK);
        send(8'hC3, SC_D_ACK);
        ack_on = 1'b0;
        send(8'h3C, SC_D_NACK);
        wr(OFF_CONTROL, 8'hA5);
        wait_step(SC_RSTART);
        send(8'h54, SC_AW_NACK);
        ack_on = 1'b1;
        s0 = stop_cnt;
        wr(OFF_CONTROL, 8'hB5);
        wait_step(SC_START);
        chk("stops", stop_cnt, s0 + 8'h01);
        rchk("stop bit", OFF_CONTROL, 8'h10, 8'h00);
        send(8'h54, SC_AW_ACK);
        wr(OFF_CONTROL, 8'hA5);
        wait_step(SC_RSTART);
        send(8'h55, SC_AR_ACK);
        s0 = stop_cnt;
        wr(OFF_CONTROL, 8'h95);
        wait_stop();
        // status keeps the last event code once the bus is idle
        rchk("status", OFF_STATUS, 8'hF8, SC_AR_ACK);
        $display("test transmit done");
        wr(OFF_CONTROL, 8'hA5);
        wait_step(SC_START);
        wr(OFF_DATA, 8'h54);
        wr(OFF_CONTROL, 8'h85);
        rival_pull <= 1'b1;
        wait_step(SC_LOST);
        chk("released", {6'h00, scl_oe, sda_oe}, 8'h00);
        wr(OFF_CONTROL, 8'h85);
        rchk("status", OFF_STATUS, 8'hF8, SC_LOST);
        chk("let go", {5'h00, scl_oe, sda_oe, irq}, 8'h00);
        wr(OFF_CONTROL, 8'hA5);
        repeat (50) @(posedge ref_clk);
        chk("no start", {6'h00, sda_oe, irq}, 8'h00);
        rival_pull <= 1'b0;
        wait_step(SC_START);
        s0 = stop_cnt;
        wr(OFF_CONTROL, 8'h95);
        wait_stop();
        $display("test arbitration done");
        report_and_stop();
    end
endmodule
